//--- rtl/dsmo_pkg.sv
// Package with register map, field layouts and reset values of the block.
package dsmo_pkg;
   // ==========================================================================
   // Register indices (byte address is four times the index)
   localparam logic [3:0]  IDX_TEMP       = 4'h6;
   localparam logic [3:0]  IDX_MASK       = 4'h7;
   localparam logic [3:0]  IDX_OFFS_A     = 4'h8;
   localparam logic [3:0]  IDX_OFFS_B     = 4'h9;
   localparam logic [3:0]  IDX_SYNC_CFG   = 4'h1;
   localparam logic [3:0]  IDX_IRQ_STAT   = 4'h2;
   localparam logic [3:0]  IDX_IRQ_EN     = 4'h3;
   localparam logic [3:0]  IDX_IRQ_CLR    = 4'h4;
   localparam logic [3:0]  IDX_ACT_OFFS   = 4'h5;
   localparam int          ADDR_LSB       = 2;
   localparam int          ADDR_W         = 6;
   // ==========================================================================
   // Field layouts and reset values
   localparam int          TEMP_LSB       = 8;
   localparam int          OFFS_W         = 13;
   localparam int          ALARM_W        = 16;
   localparam logic [15:0] MASK_RST       = 16'hFFFF;
   localparam logic [15:0] ALARM_USED     = 16'hBFBC;
   localparam logic [12:0] OFFS_RST       = 13'h0000;
   localparam int          BIT_ZERO_CHK   = 15;
   localparam int          BIT_COLLIDE    = 13;
   localparam int          BIT_ONE_APART  = 12;
   localparam int          BIT_TWO_APART  = 11;
   localparam int          BIT_CONV_CLK   = 10;
   localparam int          BIT_IN_CLK     = 9;
   localparam int          BIT_OUT_FORCED = 8;
   localparam int          BIT_PATTERN    = 7;
   localparam int          BIT_LOOP_LOCK  = 5;
   localparam int          BIT_RPARITY    = 4;
   localparam int          BIT_FPARITY    = 3;
   localparam int          BIT_FRAME_PAR  = 2;
   localparam int          SYNC_AUTO_BIT  = 0;
   localparam int          IRQ_W          = 2;
   localparam int          IRQ_LOAD       = 0;
   localparam int          IRQ_ALARM      = 1;
   localparam logic [15:0] MIDSCALE       = 16'h8000;
endpackage

//--- rtl/dsmo_sync3.sv
// Three-stage input synchroniser with agreement of the last two stages.
`timescale 1ns/10ps
`default_nettype none
module dsmo_sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r, s2_r, s3_r, q_r;
   logic [W-1:0] q_nxt;

   always_comb begin
      q_nxt = q_r;
      for (int i = 0; i < W; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            q_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r  <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r  <= q_nxt;
      end
   end

   assign q = q_r;
endmodule
`default_nettype wire

//--- rtl/dsmo_midscale.sv
// Output forcing stage that drives midscale while the forced condition holds.
`timescale 1ns/10ps
`default_nettype none
module dsmo_midscale
   import dsmo_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         force_mid,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] dout_r, dout_nxt;

   always_comb begin
      dout_nxt = force_mid ? MIDSCALE[W-1:0] : din;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dout_r <= MIDSCALE[W-1:0];
      end else begin
         dout_r <= dout_nxt;
      end
   end

   assign dout = dout_r;
endmodule
`default_nettype wire

//--- rtl/dsmo_regs.sv
// Alarm mask, die temperature and A/B offset trim registers on APB.
//
// Operation
// - Die temperature reads in bits 15:8 as signed whole degrees C.
// - Temperature is read-only, zero at reset, and its bits 7:0 read zero.
// - Sixteen mask bits, 1 masks an alarm, all reset to masked.
// - Bits 15 and 13 to 7 mask zero check, FIFO, clock, forced, pattern.
// - Offset A is 13 bits in 12:0, resets to zero, 15:13 read zero.
// - With auto-sync on, an offset A write loads A and B together.
// - An offset B write alone leaves the active offsets unchanged.
// - Offset B is 13 bits in 12:0 and resets to zero.
// - While output is forced, every converter output shows 0x8000.
`timescale 1ns/10ps
`default_nettype none
module dsmo_regs
   import dsmo_pkg::*;
#(
   parameter int DW = 16
) (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [7:0]          temp_in,
   input  wire logic [ALARM_W-1:0]  alarm_in,
   input  wire logic [DW-1:0]       samp_a,
   input  wire logic [DW-1:0]       samp_b,
   output logic      [DW-1:0]       out_a,
   output logic      [DW-1:0]       out_b,
   output logic      [OFFS_W-1:0]   act_offs_a,
   output logic      [OFFS_W-1:0]   act_offs_b,
   output logic      [ALARM_W-1:0]  alarm_stat,
   output logic                     alarm_out,
   output logic                     irq
);
   // =========================================================================
   // Input synchronisers
   logic [7:0]         temp_s;
   logic [ALARM_W-1:0] alarm_s;

   dsmo_sync3 #(.W(8)) u_sync_temp (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (temp_in),
      .q     (temp_s)
   );

   dsmo_sync3 #(.W(ALARM_W)) u_sync_alarm (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (alarm_in),
      .q     (alarm_s)
   );

   // =========================================================================
   // Temperature word capture
   // The sensor word crosses bit by bit, so it is taken only after the
   // synchronised word has held still for a cycle; a half-changed word never
   // reaches the register.
   logic [7:0] temp_prev_r, temp_prev_nxt;
   logic [7:0] temp_r, temp_nxt;

   always_comb begin
      temp_prev_nxt = temp_s;
      temp_nxt      = temp_r;
      if (temp_s == temp_prev_r) begin
         temp_nxt = temp_s;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         temp_prev_r <= 8'h00;
         temp_r      <= 8'h00;
      end else begin
         temp_prev_r <= temp_prev_nxt;
         temp_r      <= temp_nxt;
      end
   end

   // =========================================================================
   // Alarm positions that exist
   // Unused positions never record, whatever the alarm pins show.
   localparam logic [31:0]        ONE      = 32'h0000_0001;
   localparam logic [ALARM_W-1:0] POS_USED = ALARM_W'(
      (ONE << BIT_ZERO_CHK) | (ONE << BIT_COLLIDE) |
      (ONE << BIT_ONE_APART) | (ONE << BIT_TWO_APART) |
      (ONE << BIT_CONV_CLK) | (ONE << BIT_IN_CLK) |
      (ONE << BIT_OUT_FORCED) | (ONE << BIT_PATTERN) |
      (ONE << BIT_LOOP_LOCK) | (ONE << BIT_RPARITY) |
      (ONE << BIT_FPARITY) | (ONE << BIT_FRAME_PAR));

   // =========================================================================
   // Register state
   logic [ALARM_W-1:0] mask_r, mask_nxt;
   logic [ALARM_W-1:0] astat_r, astat_nxt;
   logic [OFFS_W-1:0]  offs_a_r, offs_a_nxt;
   logic [OFFS_W-1:0]  offs_b_r, offs_b_nxt;
   logic [OFFS_W-1:0]  act_a_r, act_a_nxt;
   logic [OFFS_W-1:0]  act_b_r, act_b_nxt;
   logic               sync_r, sync_nxt;
   logic [IRQ_W-1:0]   istat_r, istat_nxt;
   logic [IRQ_W-1:0]   ien_r, ien_nxt;
   logic               alarm_out_r, alarm_out_nxt;
   logic               irq_r, irq_nxt;
   logic [31:0]        prdata_r, prdata_nxt;
   logic               pready_r, pready_nxt;
   logic               pslverr_r, pslverr_nxt;
   logic [IRQ_W-1:0]   ievt;
   logic               wr_en, rd_en, map_hit;
   logic [3:0]         idx;

   assign idx   = paddr[ADDR_W-1:ADDR_LSB];
   assign wr_en = psel && penable && pwrite && !pready_r;
   assign rd_en = psel && penable && !pwrite && !pready_r;

   always_comb begin
      map_hit = 1'b1;
      unique case (idx)
         IDX_TEMP, IDX_MASK, IDX_OFFS_A, IDX_OFFS_B, IDX_SYNC_CFG,
         IDX_IRQ_STAT, IDX_IRQ_EN, IDX_IRQ_CLR, IDX_ACT_OFFS: begin
            map_hit = 1'b1;
         end
         default: begin
            map_hit = 1'b0;
         end
      endcase
   end

   // =========================================================================
   // Next-state logic
   always_comb begin
      mask_nxt   = mask_r;
      offs_a_nxt = offs_a_r;
      offs_b_nxt = offs_b_r;
      act_a_nxt  = act_a_r;
      act_b_nxt  = act_b_r;
      sync_nxt   = sync_r;
      ien_nxt    = ien_r;
      istat_nxt  = istat_r;
      ievt       = '0;
      // Alarms are recorded whether or not they are masked.
      astat_nxt  = alarm_s & POS_USED;
      if (wr_en && map_hit) begin
         unique case (idx)
            IDX_MASK: begin
               mask_nxt = pwdata[ALARM_W-1:0];
            end
            IDX_OFFS_A: begin
               offs_a_nxt = pwdata[OFFS_W-1:0];
               if (sync_r) begin
                  act_a_nxt     = pwdata[OFFS_W-1:0];
                  act_b_nxt     = offs_b_r;
                  ievt[IRQ_LOAD] = 1'b1;
               end
            end
            IDX_OFFS_B: begin
               offs_b_nxt = pwdata[OFFS_W-1:0];
            end
            IDX_SYNC_CFG: begin
               sync_nxt = pwdata[SYNC_AUTO_BIT];
            end
            IDX_IRQ_EN: begin
               ien_nxt = pwdata[IRQ_W-1:0];
            end
            IDX_IRQ_CLR: begin
               istat_nxt = istat_nxt & ~pwdata[IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end
      ievt[IRQ_ALARM] = |(astat_nxt & ~mask_r);
      // A new event wins over a clear in the same cycle.
      istat_nxt     = istat_nxt | ievt;
      alarm_out_nxt = |(astat_r & ~mask_r);
      irq_nxt       = |(istat_nxt & ien_nxt);
   end

   // =========================================================================
   // APB answer, one wait state
   always_comb begin
      prdata_nxt  = 32'h0000_0000;
      pready_nxt  = psel && penable && !pready_r;
      pslverr_nxt = psel && penable && !pready_r && !map_hit;
      if (rd_en) begin
         unique case (idx)
            IDX_TEMP: begin
               prdata_nxt[15:TEMP_LSB] = temp_r;
            end
            IDX_MASK: begin
               prdata_nxt[ALARM_W-1:0] = mask_r;
            end
            IDX_OFFS_A: begin
               prdata_nxt[OFFS_W-1:0] = offs_a_r;
            end
            IDX_OFFS_B: begin
               prdata_nxt[OFFS_W-1:0] = offs_b_r;
            end
            IDX_SYNC_CFG: begin
               prdata_nxt[SYNC_AUTO_BIT] = sync_r;
            end
            IDX_IRQ_STAT: begin
               prdata_nxt[IRQ_W-1:0] = istat_r;
            end
            IDX_IRQ_EN: begin
               prdata_nxt[IRQ_W-1:0] = ien_r;
            end
            IDX_ACT_OFFS: begin
               prdata_nxt[OFFS_W-1:0]      = act_a_r;
               prdata_nxt[16+OFFS_W-1:16]  = act_b_r;
            end
            default: begin
            end
         endcase
      end
   end

   // =========================================================================
   // Configuration and offset state
   // The stored A and B trims stay apart from the active pair until a sync
   // loads both in one edge, so the offset block never sees a mixed pair.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mask_r   <= MASK_RST;
         offs_a_r <= OFFS_RST;
         offs_b_r <= OFFS_RST;
         act_a_r  <= OFFS_RST;
         act_b_r  <= OFFS_RST;
         sync_r   <= 1'b0;
      end else begin
         mask_r   <= mask_nxt;
         offs_a_r <= offs_a_nxt;
         offs_b_r <= offs_b_nxt;
         act_a_r  <= act_a_nxt;
         act_b_r  <= act_b_nxt;
         sync_r   <= sync_nxt;
      end
   end

   // =========================================================================
   // Alarm and interrupt state
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         astat_r     <= '0;
         istat_r     <= '0;
         ien_r       <= '0;
         alarm_out_r <= 1'b0;
         irq_r       <= 1'b0;
      end else begin
         astat_r     <= astat_nxt;
         istat_r     <= istat_nxt;
         ien_r       <= ien_nxt;
         alarm_out_r <= alarm_out_nxt;
         irq_r       <= irq_nxt;
      end
   end

   // =========================================================================
   // APB answer registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // =========================================================================
   // Output forcing, applied to both converter channels
   dsmo_midscale #(.W(DW)) u_mid_a (
      .clk       (clk),
      .rst_b     (rst_b),
      .force_mid (astat_r[BIT_OUT_FORCED]),
      .din       (samp_a),
      .dout      (out_a)
   );

   dsmo_midscale #(.W(DW)) u_mid_b (
      .clk       (clk),
      .rst_b     (rst_b),
      .force_mid (astat_r[BIT_OUT_FORCED]),
      .din       (samp_b),
      .dout      (out_b)
   );

   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign act_offs_a = act_a_r;
   assign act_offs_b = act_b_r;
   assign alarm_stat = astat_r;
   assign alarm_out  = alarm_out_r;
   assign irq        = irq_r;
endmodule
`default_nettype wire

//--- verif/dsmo_apb_host.sv
// APB host model issuing single transfers to the register block.
`timescale 1ns/10ps
`default_nettype none
module dsmo_apb_host (
   input  wire logic        clk,
   output logic             psel = 1'h0,
   output logic             penable = 1'h0,
   output logic             pwrite = 1'h0,
   output logic [5:0]       paddr = 6'h00,
   output logic [31:0]      pwdata = 32'h0000_0000,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // A transfer spans three cycles or more, never faster than the bus.
   task automatic xfer(input logic wr, input logic [3:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic err,
      output logic ok);
      ok = 1'h0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      rd = 32'h0000_0000;
      err = 1'h0;
      for (int i = 0; i < 20 && !ok; i++) begin
         @(posedge clk);
         if (pready === 1'h1) begin
            ok = 1'h1;
            rd = prdata;
            err = pslverr;
         end
      end
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
endmodule
`default_nettype wire

//--- verif/dsmo_regs_asserts.sv
// Concurrent checks on the register block ports.
`timescale 1ns/10ps
`default_nettype none
module dsmo_regs_asserts
   import dsmo_pkg::*;
#(
   parameter int DW = 16
) (
   input wire logic               clk,
   input wire logic               rst_b,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [ADDR_W-1:0]  paddr,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic [ALARM_W-1:0] alarm_in,
   input wire logic [DW-1:0]      samp_a,
   input wire logic [DW-1:0]      samp_b,
   input wire logic [DW-1:0]      out_a,
   input wire logic [DW-1:0]      out_b,
   input wire logic [OFFS_W-1:0]  act_offs_a,
   input wire logic [OFFS_W-1:0]  act_offs_b,
   input wire logic [ALARM_W-1:0] alarm_stat,
   input wire logic               alarm_out
);
   wire logic rd_t = pready && !pwrite && paddr[5:2] == IDX_TEMP;
   wire logic rd_a = pready && !pwrite && paddr[5:2] == IDX_OFFS_A;
   wire logic wr_a = psel && penable && pwrite && paddr[5:2] == IDX_OFFS_A;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_temp_rsvd: assert property (
      rd_t |-> prdata[7:0] == 8'h00 && prdata[31:16] == 16'h0000)
      else $error("temperature reserved bits set");
   a_offs_rsvd: assert property (
      rd_a |-> prdata[31:13] == 19'h0_0000)
      else $error("offset reserved bits set");
   a_mid_force: assert property (
      alarm_stat[8] && $past(alarm_stat[8]) |->
      out_a == MIDSCALE && out_b == MIDSCALE)
      else $error("output not at midscale");
   a_pass_thru: assert property (
      $past(rst_b) && !alarm_stat[8] && !$past(alarm_stat[8]) |->
      out_a == $past(samp_a) && out_b == $past(samp_b))
      else $error("sample not passed through");
   a_alarm_quiet: assert property (
      $past(rst_b) && $past(alarm_stat) == 16'h0000 |-> !alarm_out)
      else $error("alarm out without recorded alarm");
   a_stat_unused: assert property (
      (alarm_stat & ~ALARM_USED) == 16'h0000)
      else $error("unused alarm position set");
   a_stat_follow: assert property (
      $stable(alarm_in) [*5] |-> alarm_stat == (alarm_in & ALARM_USED))
      else $error("alarm status not recorded");
   a_act_cause: assert property (
      $changed(act_offs_a) || $changed(act_offs_b) |->
      $past(wr_a) || $past(wr_a, 2))
      else $error("active offset moved without A write");
endmodule
`default_nettype wire

//--- verif/dsmo_regs_tb_top.sv
// Self-checking bench for the register block.
`timescale 1ns/10ps
`default_nettype none
module dsmo_regs_tb_top
   import dsmo_pkg::*;
;
   logic        clk = 1'h0;
   logic        rst_b = 1'h0;
   logic [7:0]  temp_in = 8'hE7;
   logic [15:0] alarm_in = 16'h0000;
   logic [15:0] samp_a = 16'h1234;
   logic [15:0] samp_b = 16'h4321;
   logic        psel, penable, pwrite, pready, pslverr, alarm_out, irq;
   logic [5:0]  paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [15:0] out_a, out_b, alarm_stat;
   logic [12:0] act_offs_a, act_offs_b;
   logic        errv;
   int          n_mismatch = 0;
   int          n_tests = 0;
   always #5 clk = ~clk;
   dsmo_regs i_dsmo_regs (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .temp_in(temp_in), .alarm_in(alarm_in), .samp_a(samp_a),
      .samp_b(samp_b), .out_a(out_a), .out_b(out_b),
      .act_offs_a(act_offs_a), .act_offs_b(act_offs_b),
      .alarm_stat(alarm_stat), .alarm_out(alarm_out), .irq(irq));
   dsmo_apb_host i_dsmo_apb_host (.clk(clk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // ========
   // Shared tasks
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rw(input logic wr, input logic [3:0] idx,
      input logic [31:0] wd);
      logic ok;
      i_dsmo_apb_host.xfer(wr, idx, wd, rdv, errv, ok);
      if (ok !== 1'h1) begin
         n_mismatch++;
         stop_test();
      end
   endtask
   // ========
   // Scenarios
   task automatic t_reset;
      rw(1'h0, IDX_MASK, 32'h0000_0000);
      chk("mask", rdv, 32'h0000_FFFF);
      rw(1'h0, IDX_OFFS_A, 32'h0000_0000);
      chk("offs_a", rdv, 32'h0000_0000);
      rw(1'h0, IDX_OFFS_B, 32'h0000_0000);
      chk("offs_b", rdv, 32'h0000_0000);
      rw(1'h1, IDX_TEMP, 32'h0000_00FF);
      rw(1'h0, IDX_TEMP, 32'h0000_0000);
      chk("temp", rdv, 32'h0000_E700);
      $display("t_reset done");
   endtask
   task automatic t_alarm;
      alarm_in <= 16'hFFFF;
      rw(1'h1, IDX_IRQ_EN, 32'h0000_0002);
      repeat (6) @(negedge clk);
      chk("stat", 32'(alarm_stat), 32'h0000_BFBC);
      chk("masked", 32'(alarm_out), 32'h0000_0000);
      chk("forced", 32'(out_a), 32'h0000_8000);
      chk("forced_b", 32'(out_b), 32'h0000_8000);
      rw(1'h1, IDX_MASK, 32'h0000_FFFB);
      repeat (3) @(negedge clk);
      chk("unmasked", 32'(alarm_out), 32'h0000_0001);
      chk("irq_on", 32'(irq), 32'h0000_0001);
      rw(1'h1, IDX_IRQ_EN, 32'h0000_0000);
      rw(1'h0, IDX_IRQ_STAT, 32'h0000_0000);
      chk("irq_stat", rdv, 32'h0000_0002);
      chk("irq_off", 32'(irq), 32'h0000_0000);
      rw(1'h1, IDX_MASK, 32'h0000_FFFF);
      alarm_in <= 16'h0000;
      repeat (6) @(negedge clk);
      rw(1'h1, IDX_IRQ_CLR, 32'h0000_0002);
      rw(1'h1, IDX_IRQ_EN, 32'h0000_0003);
      repeat (2) @(negedge clk);
      chk("irq_clr", 32'(irq), 32'h0000_0000);
      chk("pass", 32'(out_a), 32'h0000_1234);
      chk("pass_b", 32'(out_b), 32'h0000_4321);
      $display("t_alarm done");
   endtask
   task automatic t_offs;
      rw(1'h1, IDX_OFFS_B, 32'h0000_1ABC);
      rw(1'h1, IDX_OFFS_A, 32'h0000_0123);
      chk("no_sync", 32'(act_offs_a), 32'h0000_0000);
      rw(1'h1, IDX_SYNC_CFG, 32'h0000_0001);
      rw(1'h1, IDX_OFFS_B, 32'h0000_0555);
      chk("b_only", 32'(act_offs_b), 32'h0000_0000);
      rw(1'h1, IDX_OFFS_A, 32'hFFFF_FFFF);
      @(negedge clk);
      chk("act", 32'({act_offs_b, act_offs_a}), 32'h00AA_BFFF);
      chk("irq_load", 32'(irq), 32'h0000_0001);
      rw(1'h0, IDX_ACT_OFFS, 32'h0000_0000);
      chk("act_reg", rdv, 32'h0555_1FFF);
      rw(1'h0, IDX_OFFS_A, 32'h0000_0000);
      chk("offs_a_w", rdv, 32'h0000_1FFF);
      rw(1'h1, IDX_IRQ_CLR, 32'h0000_0001);
      @(negedge clk);
      chk("irq_ld_clr", 32'(irq), 32'h0000_0000);
      rw(1'h0, 4'hF, 32'h0000_0000);
      chk("unmapped", {rdv[30:0], errv}, 32'h0000_0001);
      $display("t_offs done");
   endtask
   task automatic t_rst_mid;
      rw(1'h1, IDX_MASK, 32'h0000_0000);
      rst_b <= 1'h0;
      repeat (4) @(posedge clk);
      chk("rst_act", 32'(act_offs_a), 32'h0000_0000);
      chk("rst_out", 32'(out_a), 32'h0000_8000);
      rst_b <= 1'h1;
      rw(1'h0, IDX_MASK, 32'h0000_0000);
      chk("rst_mask", rdv, 32'h0000_FFFF);
      rw(1'h0, IDX_OFFS_A, 32'h0000_0000);
      chk("rst_offs_a", rdv, 32'h0000_0000);
      $display("t_rst_mid done");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'h1;
      t_reset();
      t_alarm();
      t_offs();
      t_rst_mid();
      stop_test();
   end
endmodule
bind dsmo_regs dsmo_regs_asserts #(.DW(DW)) i_dsmo_regs_asserts (
   .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .alarm_in(alarm_in), .samp_a(samp_a), .samp_b(samp_b),
   .out_a(out_a), .out_b(out_b),
   .act_offs_a(act_offs_a), .act_offs_b(act_offs_b),
   .alarm_stat(alarm_stat), .alarm_out(alarm_out));
`default_nettype wire
